/* File: gpc_defs.svh */
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH

`define GPC_ADDR_W 4
`define GPC_PORT_W 8
`define GPC_PORT_NUM 4

`define GPC_OFS_DATA0 4'h0
`define GPC_OFS_DATA1 4'h1
`define GPC_OFS_DATA2 4'h2
`define GPC_OFS_DATA3 4'h3
`define GPC_OFS_STYLE_LO0 4'h4
`define GPC_OFS_STYLE_HI0 4'h5
`define GPC_OFS_STYLE_LO1 4'h6
`define GPC_OFS_STYLE_HI1 4'h7
`define GPC_OFS_STYLE_LO2 4'h8
`define GPC_OFS_STYLE_HI2 4'h9
`define GPC_OFS_STYLE_LO3 4'hA
`define GPC_OFS_STYLE_HI3 4'hB

`define GPC_RST_DATA 8'hFF
`define GPC_RST_STYLE 8'h00
`define GPC_RD_IDLE 8'h00

`define GPC_CODE_OPEN_DRAIN 2'h0
`define GPC_CODE_QUASI 2'h1
`define GPC_CODE_HIGH_Z 2'h2
`define GPC_CODE_PUSH_PULL 2'h3

`define GPC_CLK_NS 20
`define GPC_STRONG_NS 40
`define GPC_STRONG_CYC ((`GPC_STRONG_NS + `GPC_CLK_NS - 1) / `GPC_CLK_NS)
`define GPC_STRONG_W 2

`define GPC_P3_UPPER_LSB 5
`define GPC_FULL_MASK 8'hFF
`define GPC_SMALL_P3_MASK 8'h1F

`endif

/* File: gpc_pkg.sv */
package gpc_pkg;
`include "gpc_defs.svh"

    typedef logic [`GPC_PORT_W-1:0] gpc_byte_type;

    typedef enum logic [1:0] {
        GPC_STYLE_OPEN_DRAIN = `GPC_CODE_OPEN_DRAIN,
        GPC_STYLE_QUASI = `GPC_CODE_QUASI,
        GPC_STYLE_HIGH_Z = `GPC_CODE_HIGH_Z,
        GPC_STYLE_PUSH_PULL = `GPC_CODE_PUSH_PULL
    } gpc_style_type;

    // Second register is the upper code bit
    function automatic gpc_style_type gpc_style_of(input logic hi, input logic lo);
        return gpc_style_type'({hi, lo});
    endfunction

endpackage

/* File: gpc_port_if.sv */
`timescale 1ns/100ps
interface gpc_port_if #(parameter int W = 8);
    logic [W-1:0] latch;
    logic [W-1:0] style_lo;
    logic [W-1:0] style_hi;
    logic [W-1:0] pin_out;
    logic [W-1:0] pin_oe_n;
    logic [W-1:0] pin_pullup;

    modport regs (
        output latch,
        output style_lo,
        output style_hi,
        input pin_out,
        input pin_oe_n,
        input pin_pullup
    );

    modport drv (
        input latch,
        input style_lo,
        input style_hi,
        output pin_out,
        output pin_oe_n,
        output pin_pullup
    );
endinterface

/* File: gpc_addr_decode.sv */
`timescale 1ns/100ps
`include "gpc_defs.svh"
module gpc_addr_decode
    import gpc_pkg::*;
(
    input wire logic [`GPC_ADDR_W-1:0] i_addr,
    output logic [`GPC_PORT_NUM-1:0] o_sel_data,
    output logic [`GPC_PORT_NUM-1:0] o_sel_lo,
    output logic [`GPC_PORT_NUM-1:0] o_sel_hi,
    output logic o_hit
);
    always_comb begin
        o_sel_data = '0;
        o_sel_lo = '0;
        o_sel_hi = '0;
        unique case (i_addr)
            `GPC_OFS_DATA0: o_sel_data[0] = 1'b1;
            `GPC_OFS_DATA1: o_sel_data[1] = 1'b1;
            `GPC_OFS_DATA2: o_sel_data[2] = 1'b1;
            `GPC_OFS_DATA3: o_sel_data[3] = 1'b1;
            `GPC_OFS_STYLE_LO0: o_sel_lo[0] = 1'b1;
            `GPC_OFS_STYLE_HI0: o_sel_hi[0] = 1'b1;
            `GPC_OFS_STYLE_LO1: o_sel_lo[1] = 1'b1;
            `GPC_OFS_STYLE_HI1: o_sel_hi[1] = 1'b1;
            `GPC_OFS_STYLE_LO2: o_sel_lo[2] = 1'b1;
            `GPC_OFS_STYLE_HI2: o_sel_hi[2] = 1'b1;
            `GPC_OFS_STYLE_LO3: o_sel_lo[3] = 1'b1;
            `GPC_OFS_STYLE_HI3: o_sel_hi[3] = 1'b1;
            default: ;
        endcase
        o_hit = |{o_sel_data, o_sel_lo, o_sel_hi};
    end
endmodule

/* File: gpc_port_drive.sv */
`timescale 1ns/100ps
`include "gpc_defs.svh"
module gpc_port_drive
    import gpc_pkg::*;
#(
    parameter int W = 8,
    parameter logic [W-1:0] PIN_MASK = '1
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    gpc_port_if.drv port
);
    localparam logic [`GPC_STRONG_W-1:0] STRONG_LOAD = `GPC_STRONG_W'(`GPC_STRONG_CYC - 1);

    logic [W-1:0] prev_r;
    logic [`GPC_STRONG_W-1:0] cnt_r [W];
    logic [W-1:0] out_nxt;
    logic [W-1:0] oe_n_nxt;
    logic [W-1:0] pull_nxt;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            prev_r <= `GPC_RST_DATA;
        end else begin
            prev_r <= port.latch;
        end
    end

    // Strong pull-up one-shot after a 0 to 1 latch change
    always_ff @(posedge i_sys_clk) begin
        for (int b = 0; b < W; b++) begin
            if (i_rst) begin
                cnt_r[b] <= '0;
            end else if (gpc_style_of(port.style_hi[b], port.style_lo[b]) != GPC_STYLE_QUASI
                         || !port.latch[b]) begin
                cnt_r[b] <= '0;
            end else if (!prev_r[b]) begin
                cnt_r[b] <= STRONG_LOAD; // [RULE4]
            end else if (cnt_r[b] != '0) begin
                cnt_r[b] <= cnt_r[b] - 1'b1;
            end
        end
    end

    always_comb begin
        for (int b = 0; b < W; b++) begin
            out_nxt[b] = 1'b0;
            oe_n_nxt[b] = 1'b1;
            pull_nxt[b] = 1'b0;
            unique case (gpc_style_of(port.style_hi[b], port.style_lo[b])) // [RULE2] [RULE8]
                GPC_STYLE_OPEN_DRAIN: begin
                    oe_n_nxt[b] = port.latch[b]; // [RULE3]
                end
                GPC_STYLE_QUASI: begin
                    pull_nxt[b] = 1'b1; // [RULE4]
                    out_nxt[b] = port.latch[b];
                    oe_n_nxt[b] = port.latch[b] && prev_r[b] && cnt_r[b] == '0;
                end
                GPC_STYLE_HIGH_Z: begin
                    oe_n_nxt[b] = 1'b1; // [RULE5]
                end
                GPC_STYLE_PUSH_PULL: begin
                    out_nxt[b] = port.latch[b]; // [RULE6]
                    oe_n_nxt[b] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            port.pin_out <= '0;
            port.pin_oe_n <= '1;
            port.pin_pullup <= '0;
        end else begin
            port.pin_out <= out_nxt & PIN_MASK; // [RULE7]
            port.pin_oe_n <= oe_n_nxt | ~PIN_MASK;
            port.pin_pullup <= pull_nxt & PIN_MASK;
        end
    end
endmodule

/* File: gpc_top.sv */
// Behaviour
// RULE1: Four 8-bit port latches, one per port
// RULE2: Pin n style from bit n of both
// RULE3: Code 00 gives open-drain output
// RULE4: Code 01 gives quasi-bidirectional pin
// RULE5: Code 10 leaves pin high-impedance input
// RULE6: Code 11 drives push-pull both ways
// RULE7: Port 3 bits 7-5 only full package
// RULE8: Second register bit is code upper bit
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "gpc_defs.svh"
module gpc_top
    import gpc_pkg::*;
#(
    parameter bit FULL_PKG = 1'b1
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [`GPC_ADDR_W-1:0] i_addr,
    input wire logic [`GPC_PORT_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`GPC_PORT_W-1:0] o_rdata,
    input wire logic [`GPC_PORT_NUM*`GPC_PORT_W-1:0] i_pin_in,
    output logic [`GPC_PORT_NUM*`GPC_PORT_W-1:0] o_pin_out,
    output logic [`GPC_PORT_NUM*`GPC_PORT_W-1:0] o_pin_oe_n,
    output logic [`GPC_PORT_NUM*`GPC_PORT_W-1:0] o_pin_pullup
);
    localparam int NP = `GPC_PORT_NUM;
    localparam int PW = `GPC_PORT_W;
    localparam int NPIN = NP * PW;
    localparam logic [PW-1:0] P3_MASK = FULL_PKG ? `GPC_FULL_MASK : `GPC_SMALL_P3_MASK;
    localparam logic [NPIN-1:0] PIN_MASK_ALL = {P3_MASK, {(NPIN-PW){1'b1}}};

    gpc_byte_type data_r [NP];
    gpc_byte_type style_lo_r [NP];
    gpc_byte_type style_hi_r [NP];
    gpc_byte_type rdata_r;
    gpc_byte_type rdata_nxt;

    logic [NP-1:0] sel_data;
    logic [NP-1:0] sel_lo;
    logic [NP-1:0] sel_hi;
    logic hit;

    logic [NPIN-1:0] latch_all;
    logic [NPIN-1:0] lo_all;
    logic [NPIN-1:0] hi_all;

    gpc_port_if #(.W(PW)) port_if [NP] ();

    gpc_addr_decode u_dec (
        .i_addr(i_addr),
        .o_sel_data(sel_data),
        .o_sel_lo(sel_lo),
        .o_sel_hi(sel_hi),
        .o_hit(hit)
    );

    // Port latches
    always_ff @(posedge i_sys_clk) begin
        for (int p = 0; p < NP; p++) begin
            if (i_rst) begin
                data_r[p] <= `GPC_RST_DATA;
            end else if (i_wr && sel_data[p]) begin
                data_r[p] <= i_wdata; // [RULE1]
            end
        end
    end

    // Style registers, lower code bit
    always_ff @(posedge i_sys_clk) begin
        for (int p = 0; p < NP; p++) begin
            if (i_rst) begin
                style_lo_r[p] <= `GPC_RST_STYLE;
            end else if (i_wr && sel_lo[p]) begin
                style_lo_r[p] <= i_wdata; // [RULE2]
            end
        end
    end

    // Style registers, upper code bit
    always_ff @(posedge i_sys_clk) begin
        for (int p = 0; p < NP; p++) begin
            if (i_rst) begin
                style_hi_r[p] <= `GPC_RST_STYLE;
            end else if (i_wr && sel_hi[p]) begin
                style_hi_r[p] <= i_wdata; // [RULE8]
            end
        end
    end

    // Data reads return pin levels; absent pins return the latch
    always_comb begin
        rdata_nxt = `GPC_RD_IDLE;
        for (int p = 0; p < NP; p++) begin
            if (sel_data[p]) begin
                rdata_nxt = (i_pin_in[p*PW +: PW] & PIN_MASK_ALL[p*PW +: PW])
                          | (data_r[p] & ~PIN_MASK_ALL[p*PW +: PW]); // [RULE1] [RULE7]
            end
            if (sel_lo[p]) begin
                rdata_nxt = style_lo_r[p];
            end
            if (sel_hi[p]) begin
                rdata_nxt = style_hi_r[p];
            end
        end
        if (!hit) begin
            rdata_nxt = `GPC_RD_IDLE;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rdata_r <= `GPC_RD_IDLE;
        end else if (i_rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= `GPC_RD_IDLE;
        end
    end

    assign o_rdata = rdata_r;

    for (genvar p = 0; p < NP; p++) begin : g_port
        assign port_if[p].latch = data_r[p];
        assign port_if[p].style_lo = style_lo_r[p];
        assign port_if[p].style_hi = style_hi_r[p];
        assign o_pin_out[p*PW +: PW] = port_if[p].pin_out;
        assign o_pin_oe_n[p*PW +: PW] = port_if[p].pin_oe_n;
        assign o_pin_pullup[p*PW +: PW] = port_if[p].pin_pullup;
        assign latch_all[p*PW +: PW] = data_r[p];
        assign lo_all[p*PW +: PW] = style_lo_r[p];
        assign hi_all[p*PW +: PW] = style_hi_r[p];

        gpc_port_drive #(
            .W(PW),
            .PIN_MASK(PIN_MASK_ALL[p*PW +: PW]) // [RULE7]
        ) u_drv (
            .i_sys_clk(i_sys_clk),
            .i_rst(i_rst),
            .port(port_if[p])
        );
    end

    // Register bus checks
    chk_latch_write: assert property ( // [RULE1]
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_wr && i_addr == `GPC_OFS_DATA0)
        |=> data_r[0] == $past(i_wdata)
    ) else $error("port latch did not take written byte");

    chk_latch_hold: assert property ( // [RULE1]
        @(posedge i_sys_clk) disable iff (i_rst)
        !(i_wr && sel_data[3]) |=> $stable(data_r[3])
    ) else $error("port 3 latch changed without a write");

    chk_style_pair: assert property ( // [RULE2]
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_wr && i_addr == `GPC_OFS_STYLE_HI2)
        |=> (style_hi_r[2] == $past(i_wdata)) && $stable(style_lo_r[2])
    ) else $error("upper style write disturbed the wrong register");

    chk_read_timing: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_rd && i_addr == `GPC_OFS_STYLE_LO1)
        |=> o_rdata == $past(style_lo_r[1]) ##1 ($past(i_rd) || o_rdata == `GPC_RD_IDLE)
    ) else $error("read data not in the cycle after the strobe");

    chk_read_pin: assert property ( // [RULE1]
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_rd && i_addr == `GPC_OFS_DATA0) |=> o_rdata == $past(i_pin_in[PW-1:0])
    ) else $error("port 0 read did not return pin levels");

    chk_read_unmapped: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_rd && !hit) |=> o_rdata == `GPC_RD_IDLE
    ) else $error("unmapped read returned data");

    chk_read_idle: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        !i_rd |=> o_rdata == `GPC_RD_IDLE
    ) else $error("read data present without a read strobe");

    // Per-pin output style checks
    for (genvar n = 0; n < NPIN; n++) begin : g_chk
        if (PIN_MASK_ALL[n]) begin : g_present
            chk_open_drain: assert property ( // [RULE3]
                @(posedge i_sys_clk) disable iff (i_rst)
                ({hi_all[n], lo_all[n]} == `GPC_CODE_OPEN_DRAIN)
                |=> !o_pin_out[n] && !o_pin_pullup[n]
                    && o_pin_oe_n[n] == $past(latch_all[n])
            ) else $error("open-drain pin drove high or missed low");

            chk_quasi_low: assert property ( // [RULE4]
                @(posedge i_sys_clk) disable iff (i_rst)
                ({hi_all[n], lo_all[n]} == `GPC_CODE_QUASI && !latch_all[n])
                |=> !o_pin_oe_n[n] && !o_pin_out[n] && o_pin_pullup[n]
            ) else $error("quasi pin not pulled low for a zero latch");

            chk_quasi_strong: assert property ( // [RULE4]
                @(posedge i_sys_clk) disable iff (i_rst)
                ({hi_all[n], lo_all[n]} == `GPC_CODE_QUASI && $rose(latch_all[n]))
                ##1 ({hi_all[n], lo_all[n]} == `GPC_CODE_QUASI && latch_all[n])
                |-> (!o_pin_oe_n[n] && o_pin_out[n]) ##1 (!o_pin_oe_n[n] && o_pin_out[n])
            ) else $error("quasi pin missed its strong high pulse");

            chk_quasi_weak: assert property ( // [RULE4]
                @(posedge i_sys_clk) disable iff (i_rst)
                ({hi_all[n], lo_all[n]} == `GPC_CODE_QUASI && latch_all[n])[*3]
                |=> o_pin_oe_n[n] && o_pin_pullup[n]
            ) else $error("quasi pin kept driving after strong pulse");

            chk_high_z: assert property ( // [RULE5]
                @(posedge i_sys_clk) disable iff (i_rst)
                ({hi_all[n], lo_all[n]} == `GPC_CODE_HIGH_Z)
                |=> o_pin_oe_n[n] && !o_pin_pullup[n] && !o_pin_out[n]
            ) else $error("high-impedance pin was driven");

            chk_push_pull: assert property ( // [RULE6]
                @(posedge i_sys_clk) disable iff (i_rst)
                ({hi_all[n], lo_all[n]} == `GPC_CODE_PUSH_PULL)
                |=> !o_pin_oe_n[n] && o_pin_out[n] == $past(latch_all[n])
            ) else $error("push-pull pin did not follow its latch");

            chk_code_order: assert property ( // [RULE8]
                @(posedge i_sys_clk) disable iff (i_rst)
                (hi_all[n] && !lo_all[n]) |=> o_pin_oe_n[n]
            ) else $error("code bit halves taken in the wrong order");
        end else begin : g_absent
            chk_absent_pin: assert property ( // [RULE7]
                @(posedge i_sys_clk) disable iff (i_rst)
                1'b1 |=> o_pin_oe_n[n] && !o_pin_out[n] && !o_pin_pullup[n]
            ) else $error("absent port 3 pin was driven");
        end
    end

    chk_reset_released: assert property (
        @(posedge i_sys_clk)
        i_rst |=> o_pin_oe_n == '1 && o_rdata == `GPC_RD_IDLE && data_r[0] == `GPC_RST_DATA
    ) else $error("reset did not release pins and latches");
endmodule

/* File: gpc_pin_board.sv */
`timescale 1ns/100ps
module gpc_pin_board (
    input wire logic [31:0] i_pin_out,
    input wire logic [31:0] i_pin_oe_n,
    input wire logic [31:0] i_pin_pullup,
    input wire logic [31:0] i_ext_en,
    input wire logic [31:0] i_ext_val,
    output logic [31:0] o_level
);
    // Board pull-up on every pin; device or external part may pull low
    always_comb begin
        o_level = (i_pin_oe_n | i_pin_out) & (~i_ext_en | i_ext_val) | (i_pin_pullup & 32'h0);
    end
endmodule

/* File: gpio_port_config_bench.sv */
`timescale 1ns/100ps
`include "gpc_defs.svh"
module gpio_port_config_bench
    import gpc_pkg::*;
;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] ext_en = 32'h0;
    logic [31:0] ext_val = 32'h0;
    logic [7:0] o_rdata, s_rdata;
    logic [31:0] pin_in, o_pin_out, o_pin_oe_n, o_pin_pullup, s_out, s_oe_n, s_pu;
    int miscompares = 0;
    int n_tests = 0;

    gpc_top uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(pin_in), .o_pin_out(o_pin_out),
        .o_pin_oe_n(o_pin_oe_n), .o_pin_pullup(o_pin_pullup));
    gpc_top #(.FULL_PKG(1'b0)) uut_small (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(s_rdata), .i_pin_in(pin_in),
        .o_pin_out(s_out), .o_pin_oe_n(s_oe_n), .o_pin_pullup(s_pu));
    gpc_pin_board board (.i_pin_out(o_pin_out), .i_pin_oe_n(o_pin_oe_n),
        .i_pin_pullup(o_pin_pullup), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pin_in));

    always #10 i_sys_clk = ~i_sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        chk({24'h0, o_rdata}, {24'h0, exp});
    endtask

    task automatic t_reset();
        for (int a = 0; a < 12; a++) begin
            rd(a[3:0], (a < 4) ? `GPC_RST_DATA : `GPC_RST_STYLE);
        end
        chk(o_pin_oe_n, 32'hFFFFFFFF);
        chk(o_pin_pullup, 32'h0);
        $display("Test reset done");
    endtask

    // Pin n code = {hi[n], lo[n]}: AA/CC gives OD, quasi, high-Z, push-pull in turn
    task automatic t_codes(input int p, input logic [7:0] lat);
        logic [7:0] oe, ov, pu, hz, lvl;
        wr(4'(4 + 2 * p), 8'hAA);
        wr(4'(5 + 2 * p), 8'hCC);
        wr(4'(p), lat);
        repeat (5) @(posedge i_sys_clk);
        #1;
        for (int n = 0; n < 8; n++) begin
            case (gpc_style_type'({n[1], n[0]}))
                GPC_STYLE_OPEN_DRAIN: {oe[n], ov[n], pu[n]} = {lat[n], 1'b0, 1'b0};
                GPC_STYLE_QUASI: {oe[n], ov[n], pu[n]} = {lat[n], 1'b0, 1'b1};
                GPC_STYLE_HIGH_Z: {oe[n], ov[n], pu[n]} = 3'b100;
                default: {oe[n], ov[n], pu[n]} = {1'b0, lat[n], 1'b0};
            endcase
        end
        hz = 8'h44;
        chk(o_pin_oe_n[p*8+:8], oe);
        chk(o_pin_pullup[p*8+:8], pu);
        chk(o_pin_out[p*8+:8] & ~oe, ov);
        ext_en[p*8+:8] <= hz;
        lvl = (oe | ov) & ~hz;
        rd(4'(p), lvl);
        ext_en <= 32'h0;
        $display("Test codes port %0d done", p);
    endtask

    task automatic t_quasi();
        wr(4'h6, 8'hFF);
        wr(4'h7, 8'h00);
        wr(4'h1, 8'h00);
        repeat (4) @(posedge i_sys_clk);
        wr(4'h1, 8'hFF);
        repeat (1) @(posedge i_sys_clk);
        #1;
        chk({o_pin_oe_n[15:8], o_pin_out[15:8]}, 16'h00FF);
        @(posedge i_sys_clk);
        #1;
        chk({o_pin_oe_n[15:8], o_pin_out[15:8]}, 16'h00FF);
        @(posedge i_sys_clk);
        #1;
        chk({o_pin_oe_n[15:8], o_pin_pullup[15:8]}, 16'hFFFF);
        $display("Test quasi done");
    endtask

    task automatic t_unmapped();
        wr(4'h4, 8'h3C);
        for (int a = 12; a < 16; a++) begin
            wr(a[3:0], 8'h5A);
            rd(a[3:0], 8'h00);
        end
        rd(4'h4, 8'h3C);
        @(posedge i_sys_clk);
        #1;
        chk({24'h0, o_rdata}, 32'h0);
        $display("Test unmapped done");
    endtask

    task automatic t_small();
        wr(4'hA, 8'hFF);
        wr(4'hB, 8'hFF);
        wr(4'h3, 8'hA0);
        repeat (4) @(posedge i_sys_clk);
        #1;
        chk(s_oe_n[31:24], 32'hE0);
        chk({s_out[31:29], s_pu[31:29]}, 32'h0);
        chk({o_pin_oe_n[31:24], o_pin_out[31:24]}, 32'h00A0);
        rd(4'h3, 8'hA0);
        chk({24'h0, s_rdata}, 32'hA0);
        $display("Test small package done");
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #(20 * 3000);
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        t_reset();
        t_codes(0, 8'h5A);
        t_codes(1, 8'hF0);
        t_codes(2, 8'h0F);
        t_codes(3, 8'hA5);
        t_quasi();
        t_unmapped();
        t_small();
        end_sim();
    end
endmodule
